// file: afsf_map.svh
`ifndef AFSF_MAP_SVH
`define AFSF_MAP_SVH

// Audio word length limits per channel, in bits
`define AFSF_MIN_WORD      6'h08
`define AFSF_MAX_WORD      6'h20
// Default channel slot width and TDM slot count
`define AFSF_SLOT_BITS     32
`define AFSF_TDM_SLOTS     4
// Bit clocks that a long PCM frame sync stays high
`define AFSF_PCM_LONG_HIGH 13
// Configuration values held in reset
`define AFSF_RST_WORD_LEN  6'h20
`define AFSF_RST_DSP_WIDTH 6'h01

`endif

// file: afsf_pkg.sv
package afsf_pkg;

   typedef enum logic [2:0] {
      AFSF_I2S       = 3'h0,
      AFSF_LJ        = 3'h1,
      AFSF_RJ        = 3'h2,
      AFSF_DSP       = 3'h3,
      AFSF_DSP_DLY   = 3'h4,
      AFSF_TDM       = 3'h5,
      AFSF_PCM_SHORT = 3'h6,
      AFSF_PCM_LONG  = 3'h7
   } afsf_fmt_type;

   typedef enum logic [1:0] {
      AFSF_IDLE = 2'h0,
      AFSF_HUNT = 2'h1,
      AFSF_RUN  = 2'h3
   } afsf_state_type;

   typedef struct packed {
      logic       hit;
      logic       chan;
      logic [4:0] idx;
   } afsf_loc_type;

endpackage : afsf_pkg

// file: afsf_core.sv
`timescale 1ns/1ps
`include "afsf_map.svh"

module afsf_core
   import afsf_pkg::*;
#(
   parameter int SLOT_BITS = `AFSF_SLOT_BITS,
   parameter int TDM_SLOTS = `AFSF_TDM_SLOTS,
   localparam int POS_W    = $clog2(TDM_SLOTS * SLOT_BITS)
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             link_clk,
   input  wire logic             enable,
   input  wire logic             master_sel,
   input  wire logic [2:0]       format_sel,
   input  wire logic [5:0]       word_len,
   input  wire logic [5:0]       dsp_width,
   input  wire logic             gap_en,
   input  wire logic [POS_W-1:0] tdm_offset,
   input  wire logic [31:0]      tx_left,
   input  wire logic [31:0]      tx_right,
   input  wire logic             tx_valid,
   output logic                  tx_ready,
   output logic [31:0]           rx_left,
   output logic [31:0]           rx_right,
   output logic                  rx_valid,
   input  wire logic             word_select_in,
   output logic                  word_select_out,
   output logic                  word_select_oe,
   input  wire logic             serial_data_in,
   output logic                  serial_data_out,
   output logic                  serial_data_oe
);

   localparam logic [POS_W-1:0] SLOT_P = POS_W'(SLOT_BITS);

   if (SLOT_BITS < `AFSF_PCM_LONG_HIGH + 1 || SLOT_BITS > 32 || TDM_SLOTS < 3) begin : g_bad
      $error("afsf_core: slot width must be 14..32 and TDM slots at least 3");
   end

   function automatic logic [POS_W-1:0] afsf_last(input afsf_fmt_type f);
      logic [POS_W-1:0] r;
      r = POS_W'(2 * SLOT_BITS - 1);
      if (f == AFSF_TDM) begin
         r = POS_W'(TDM_SLOTS * SLOT_BITS - 1);
      end else if (f == AFSF_PCM_SHORT || f == AFSF_PCM_LONG) begin
         r = POS_W'(SLOT_BITS - 1);
      end
      return r;
   endfunction : afsf_last

   function automatic logic afsf_ws_level(input afsf_fmt_type     f,
                                          input logic [POS_W-1:0] p,
                                          input logic [5:0]       dw);
      logic r;
      r = 1'b0;
      unique case (f)
         AFSF_I2S:                              r = (p >= SLOT_P);
         AFSF_LJ, AFSF_RJ:                      r = (p < SLOT_P);
         AFSF_DSP:                              r = (p < POS_W'(dw));
         AFSF_DSP_DLY, AFSF_TDM, AFSF_PCM_SHORT: r = (p == '0);
         AFSF_PCM_LONG: r = (p < POS_W'(`AFSF_PCM_LONG_HIGH));
      endcase
      return r;
   endfunction : afsf_ws_level

   // Bit index within the frame, counted from the first data bit
   function automatic logic [POS_W-1:0] afsf_rel(input afsf_fmt_type     f,
                                                 input logic [POS_W-1:0] p,
                                                 input logic [POS_W-1:0] off);
      logic [POS_W-1:0] base;
      logic [POS_W:0]   wrap;
      base = '0;
      if (f == AFSF_I2S || f == AFSF_DSP_DLY || f == AFSF_PCM_SHORT) begin
         base = POS_W'(1);
      end else if (f == AFSF_TDM) begin
         base = off;
      end
      wrap = {1'b0, p} + {1'b0, afsf_last(f)} + (POS_W+1)'(1) - {1'b0, base};
      return (p >= base) ? POS_W'(p - base) : wrap[POS_W-1:0];
   endfunction : afsf_rel

   function automatic afsf_loc_type afsf_locate(input afsf_fmt_type     f,
                                                input logic [POS_W-1:0] b,
                                                input logic [5:0]       wl,
                                                input logic             gap);
      afsf_loc_type     l;
      logic [POS_W-1:0] stride;
      logic [POS_W-1:0] k;
      logic [POS_W-1:0] wlp;
      logic [POS_W-1:0] pad;
      l      = '0;
      wlp    = POS_W'(wl);
      pad    = SLOT_P - wlp;
      stride = SLOT_P;
      if ((f == AFSF_DSP || f == AFSF_DSP_DLY) && !gap) begin
         stride = wlp;
      end
      if (f == AFSF_TDM || f == AFSF_PCM_SHORT || f == AFSF_PCM_LONG) begin
         k = b;
      end else begin
         l.chan = (b >= stride);
         k      = l.chan ? POS_W'(b - stride) : b;
      end
      if (f == AFSF_RJ) begin
         l.hit = (k >= pad) && (k < stride);
         l.idx = 5'(k - pad);
      end else begin
         l.hit = (k < wlp);
         l.idx = 5'(k);
      end
      return l;
   endfunction : afsf_locate

   // Bit position of a word index counted from the MSB
   function automatic logic [4:0] afsf_bitpos(input logic [5:0] wl, input logic [4:0] idx);
      logic [5:0] i;
      i = wl - 6'h01 - {1'b0, idx};
      return i[4:0];
   endfunction : afsf_bitpos

   function automatic logic [31:0] afsf_sext(input logic [31:0] w, input logic [5:0] wl);
      logic [31:0] r;
      r = w;
      for (int i = 0; i < 32; i++) begin
         if (6'(i) >= wl) begin
            r[i] = w[afsf_bitpos(wl, 5'h00)];
         end
      end
      return r;
   endfunction : afsf_sext

   // Core domain
   logic             cfg_master;
   afsf_fmt_type     cfg_fmt;
   logic [5:0]       cfg_wl;
   logic [5:0]       cfg_dw;
   logic             cfg_gap;
   logic [POS_W-1:0] cfg_off;
   logic [31:0]      tx_hold_l;
   logic [31:0]      tx_hold_r;
   logic             tx_req;
   logic             ack_s1;
   logic             ack_s2;
   logic             rx_s1;
   logic             rx_s2;
   logic             rx_s3;

   // Link domain
   afsf_state_type   state;
   logic [POS_W-1:0] pos;
   logic             en_s1;
   logic             en_s2;
   logic             req_s1;
   logic             req_s2;
   logic             ws_q;
   logic             l_master;
   afsf_fmt_type     l_fmt;
   logic [5:0]       l_wl;
   logic [5:0]       l_dw;
   logic             l_gap;
   logic [POS_W-1:0] l_off;
   logic [31:0]      tx_frame_l;
   logic [31:0]      tx_frame_r;
   logic             tx_ack;
   logic [31:0]      rx_sh_l;
   logic [31:0]      rx_sh_r;
   logic [31:0]      rx_hold_l;
   logic [31:0]      rx_hold_r;
   logic             rx_tgl;

   logic             start_seen;
   logic             step;
   logic             rx_go;
   logic             stop;
   logic             load;
   logic             push;
   logic             fresh;
   logic [POS_W-1:0] last;
   logic [POS_W-1:0] cur;
   logic [POS_W-1:0] nxt;
   afsf_loc_type     loc_cur;
   afsf_loc_type     loc_nxt;
   logic [31:0]      next_tx_l;
   logic [31:0]      next_tx_r;
   logic [31:0]      next_rx_l;
   logic [31:0]      next_rx_r;

   // Configuration is frozen while the interface runs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_master <= 1'b0;
         cfg_fmt    <= AFSF_I2S;
         cfg_wl     <= `AFSF_RST_WORD_LEN;
         cfg_dw     <= `AFSF_RST_DSP_WIDTH;
         cfg_gap    <= 1'b0;
         cfg_off    <= '0;
      end else if (!enable) begin
         cfg_master <= master_sel;
         cfg_fmt    <= afsf_fmt_type'(format_sel);
         if (word_len < `AFSF_MIN_WORD) begin
            cfg_wl <= `AFSF_MIN_WORD;
         end else if (word_len > 6'(SLOT_BITS)) begin
            cfg_wl <= 6'(SLOT_BITS);
         end else begin
            cfg_wl <= word_len;
         end
         cfg_dw  <= (dsp_width == 6'h00) ? 6'h01 : dsp_width;
         cfg_gap <= gap_en;
         cfg_off <= tdm_offset;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_hold_l <= 32'h0000_0000;
         tx_hold_r <= 32'h0000_0000;
         tx_req    <= 1'b0;
         tx_ready  <= 1'b1;
      end else if (tx_ready && tx_valid) begin
         tx_hold_l <= tx_left;
         tx_hold_r <= tx_right;
         tx_req    <= ~tx_req;
         tx_ready  <= 1'b0;
      end else if (!tx_ready && ack_s2 == tx_req) begin
         tx_ready  <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         rx_s1  <= 1'b0;
         rx_s2  <= 1'b0;
         rx_s3  <= 1'b0;
      end else begin
         ack_s1 <= tx_ack;
         ack_s2 <= ack_s1;
         rx_s1  <= rx_tgl;
         rx_s2  <= rx_s1;
         rx_s3  <= rx_s2;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_left  <= 32'h0000_0000;
         rx_right <= 32'h0000_0000;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= rx_s2 ^ rx_s3;
         if (rx_s2 ^ rx_s3) begin
            rx_left  <= afsf_sext(rx_hold_l, cfg_wl);
            rx_right <= afsf_sext(rx_hold_r, cfg_wl);
         end
      end
   end

   // Link domain
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_s1  <= 1'b0;
         en_s2  <= 1'b0;
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         ws_q   <= 1'b0;
      end else begin
         en_s1  <= enable;
         en_s2  <= en_s1;
         req_s1 <= tx_req;
         req_s2 <= req_s1;
         ws_q   <= word_select_in;
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         l_master <= 1'b0;
         l_fmt    <= AFSF_I2S;
         l_wl     <= `AFSF_RST_WORD_LEN;
         l_dw     <= `AFSF_RST_DSP_WIDTH;
         l_gap    <= 1'b0;
         l_off    <= '0;
      end else if (state == AFSF_IDLE && en_s2) begin
         l_master <= cfg_master;
         l_fmt    <= cfg_fmt;
         l_wl     <= cfg_wl;
         l_dw     <= cfg_dw;
         l_gap    <= cfg_gap;
         l_off    <= cfg_off;
      end
   end

   always_comb begin
      last = afsf_last(l_fmt);
      // A slave takes its frame start from the line
      start_seen = (l_fmt == AFSF_I2S) ? (ws_q & ~word_select_in)
                                       : (~ws_q & word_select_in);
      if (!l_master && start_seen) begin
         cur = '0;
      end else if (state == AFSF_HUNT) begin
         cur = last;
      end else begin
         cur = pos;
      end
      step    = (state == AFSF_RUN) || (state == AFSF_HUNT && (l_master || start_seen));
      rx_go   = (state == AFSF_RUN) || (state == AFSF_HUNT && !l_master && start_seen);
      nxt     = (cur == last) ? '0 : cur + POS_W'(1);
      // A slave still waiting for its start edge must be able to stop too
      stop    = !en_s2 && ((state == AFSF_HUNT) || (state == AFSF_RUN && nxt == '0));
      loc_cur = afsf_locate(l_fmt, afsf_rel(l_fmt, cur, l_off), l_wl, l_gap);
      loc_nxt = afsf_locate(l_fmt, afsf_rel(l_fmt, nxt, l_off), l_wl, l_gap);
      // No sample is taken for a frame that will not be sent
      load    = step && !stop && (afsf_rel(l_fmt, nxt, l_off) == '0);
      push    = rx_go && (afsf_rel(l_fmt, cur, l_off) == last);
      fresh   = (req_s2 != tx_ack);
      next_tx_l = tx_frame_l;
      next_tx_r = tx_frame_r;
      if (load) begin
         next_tx_l = fresh ? tx_hold_l : 32'h0000_0000;
         next_tx_r = fresh ? tx_hold_r : 32'h0000_0000;
      end
      next_rx_l = rx_sh_l;
      next_rx_r = rx_sh_r;
      if (rx_go && loc_cur.hit) begin
         if (loc_cur.chan) begin
            next_rx_r[afsf_bitpos(l_wl, loc_cur.idx)] = serial_data_in;
         end else begin
            next_rx_l[afsf_bitpos(l_wl, loc_cur.idx)] = serial_data_in;
         end
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= AFSF_IDLE;
         pos   <= '0;
      end else begin
         unique case (state)
            AFSF_IDLE: begin
               pos <= '0;
               if (en_s2) begin
                  state <= AFSF_HUNT;
               end
            end
            AFSF_HUNT: begin
               if (stop) begin
                  state <= AFSF_IDLE;
               end else if (step) begin
                  state <= AFSF_RUN;
                  pos   <= nxt;
               end
            end
            AFSF_RUN: begin
               pos <= nxt;
               if (stop) begin
                  state <= AFSF_IDLE;
               end
            end
            default: begin
               state <= AFSF_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_select_out <= 1'b0;
         word_select_oe  <= 1'b0;
         serial_data_out <= 1'b0;
         serial_data_oe  <= 1'b0;
      end else if (step && !stop) begin
         word_select_out <= l_master & afsf_ws_level(l_fmt, nxt, l_dw);
         word_select_oe  <= l_master;
         serial_data_oe  <= 1'b1;
         serial_data_out <= loc_nxt.hit &
            (loc_nxt.chan ? next_tx_r[afsf_bitpos(l_wl, loc_nxt.idx)]
                          : next_tx_l[afsf_bitpos(l_wl, loc_nxt.idx)]);
      end else if (state == AFSF_IDLE || stop) begin
         word_select_out <= 1'b0;
         word_select_oe  <= 1'b0;
         serial_data_out <= 1'b0;
         serial_data_oe  <= 1'b0;
      end
   end

   // A missing sample is sent as silence
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_frame_l <= 32'h0000_0000;
         tx_frame_r <= 32'h0000_0000;
         tx_ack     <= 1'b0;
      end else if (load) begin
         tx_frame_l <= next_tx_l;
         tx_frame_r <= next_tx_r;
         if (fresh) begin
            tx_ack <= ~tx_ack;
         end
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sh_l   <= 32'h0000_0000;
         rx_sh_r   <= 32'h0000_0000;
         rx_hold_l <= 32'h0000_0000;
         rx_hold_r <= 32'h0000_0000;
         rx_tgl    <= 1'b0;
      end else begin
         rx_sh_l <= next_rx_l;
         rx_sh_r <= next_rx_r;
         if (push) begin
            rx_hold_l <= next_rx_l;
            rx_hold_r <= next_rx_r;
            rx_tgl    <= ~rx_tgl;
         end
      end
   end

   sequence afsf_seq_long_high;
      ##12 word_select_out ##1 !word_select_out;
   endsequence

   chk_ws_oe_master: assert property (@(posedge link_clk) disable iff (!rst_n)
      word_select_oe |-> l_master)
      else $error("word select driven while not master");

   chk_i2s_left_msb: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_master && l_fmt == AFSF_I2S && pos == POS_W'(1)
      |-> !word_select_out && serial_data_out == tx_frame_l[afsf_bitpos(l_wl, 5'h00)])
      else $error("I2S left MSB not sent with select low");

   chk_i2s_ws_early: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_master && l_fmt == AFSF_I2S && $changed(word_select_out)
      |-> pos == '0 || pos == SLOT_P)
      else $error("I2S select changed at wrong bit");

   chk_lj_left_first: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_master && l_fmt == AFSF_LJ && pos == '0
      |-> word_select_out && serial_data_out == tx_frame_l[afsf_bitpos(l_wl, 5'h00)])
      else $error("left-justified frame start wrong");

   chk_lj_zero_tail: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_fmt == AFSF_LJ && pos >= POS_W'(l_wl) && pos < SLOT_P
      |-> !serial_data_out)
      else $error("left-justified tail not zero");

   chk_rj_lsb_last: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_fmt == AFSF_RJ && pos == SLOT_P - POS_W'(1)
      |-> serial_data_out == tx_frame_l[0])
      else $error("right-justified LSB not last");

   chk_dsp_width: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_master && l_fmt == AFSF_DSP && word_select_out
      |-> pos < POS_W'(l_dw))
      else $error("DSP select wider than set");

   chk_dsp_gap_zero: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_fmt == AFSF_DSP && l_gap && pos >= POS_W'(l_wl) && pos < SLOT_P
      |-> !serial_data_out)
      else $error("DSP gap between words not zero");

   chk_dsp_right_next: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_fmt == AFSF_DSP && !l_gap && pos == POS_W'(l_wl)
      |-> serial_data_out == tx_frame_r[afsf_bitpos(l_wl, 5'h00)])
      else $error("DSP right word does not follow left");

   chk_tdm_pulse: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_master && l_fmt == AFSF_TDM && $rose(word_select_out)
      |-> pos == '0 ##1 !word_select_out)
      else $error("TDM select pulse not one bit");

   chk_pcm_short: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_master && l_fmt == AFSF_PCM_SHORT && $rose(word_select_out)
      |=> $fell(word_select_out))
      else $error("PCM short sync not one bit");

   chk_pcm_long: assert property (@(posedge link_clk) disable iff (!rst_n)
      state == AFSF_RUN && l_master && l_fmt == AFSF_PCM_LONG && $rose(word_select_out)
      |-> pos == '0 ##0 afsf_seq_long_high)
      else $error("PCM long sync not 13 bits");

endmodule : afsf_core

// file: afsf_codec.sv
`timescale 1ns/1ps
module afsf_codec (
   input  wire logic link_clk,
   input  wire logic rst_n,
   input  wire logic drive_ws,
   input  wire logic ws_oe,
   input  wire logic ws_dev,
   input  wire logic sd_oe,
   input  wire logic sd_dev,
   output logic      ws_line,
   output logic      sd_line
);
   logic [5:0] pos;
   logic       ws_last;
   logic       sd_last;
   always @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         pos <= 6'h00;
         ws_last <= 1'b0;
         sd_last <= 1'b0;
      end else begin
         pos <= pos + 6'h01;
         ws_last <= ws_line;
         sd_last <= sd_line;
      end
   end
   // Only one side drives select; a released line shows the inverse of its last level
   assign ws_line = ws_oe ? ws_dev : (drive_ws ? (pos < 6'h20) : ~ws_last);
   // Codec echoes the device's data back, as a two's complement MSB-first stream
   assign sd_line = sd_oe ? sd_dev : ~sd_last;
endmodule : afsf_codec

// file: tb_afsf_core.sv
`timescale 1ns/1ps
module tb_afsf_core;
   import afsf_pkg::*;
   logic        core_clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        enable = 1'b0;
   logic        master_sel = 1'b1;
   logic [2:0]  format_sel = 3'h0;
   logic [5:0]  word_len = 6'h20;
   logic [5:0]  dsp_width = 6'h01;
   logic        gap_en = 1'b0;
   logic [6:0]  tdm_offset = 7'h20;
   logic [31:0] tx_left = 32'h0;
   logic [31:0] tx_right = 32'h0;
   logic        tx_valid = 1'b0;
   logic        drive_ws = 1'b0;
   logic        tx_ready, rx_valid, ws_out, ws_oe, sd_out, sd_oe, ws_line, sd_line;
   logic [31:0] rx_left, rx_right;
   int          miscompares = 0;
   int          checks = 0;
   int          cyc = 0;

   always #5 core_clk = ~core_clk;
   always #40 link_clk = ~link_clk;

   afsf_core afsf_core_i (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
      .enable(enable), .master_sel(master_sel), .format_sel(format_sel),
      .word_len(word_len), .dsp_width(dsp_width), .gap_en(gap_en),
      .tdm_offset(tdm_offset), .tx_left(tx_left), .tx_right(tx_right),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_left(rx_left), .rx_right(rx_right),
      .rx_valid(rx_valid), .word_select_in(ws_line), .word_select_out(ws_out),
      .word_select_oe(ws_oe), .serial_data_in(sd_line), .serial_data_out(sd_out),
      .serial_data_oe(sd_oe));

   afsf_codec afsf_codec_i (.link_clk(link_clk), .rst_n(rst_n), .drive_ws(drive_ws),
      .ws_oe(ws_oe), .ws_dev(ws_out), .sd_oe(sd_oe), .sd_dev(sd_out),
      .ws_line(ws_line), .sd_line(sd_line));

   task automatic conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [31:0] sx(input logic [31:0] v, input logic [5:0] wl);
      logic [31:0] t;
      t = v << (32 - wl);
      sx = $signed(t) >>> (32 - wl);
   endfunction : sx

   // Loops one sample pair through the link and measures the select period
   task automatic run_fmt(input logic [2:0] fmt, input logic ms, input logic [5:0] wl,
                          input logic gap, input logic [5:0] dw,
                          input logic [31:0] l, input logic [31:0] r);
      int  n;
      real t0;
      @(posedge core_clk);
      enable <= 1'b0;
      tx_valid <= 1'b0;
      repeat (1050) @(posedge core_clk);
      chk({30'h0, ws_oe, sd_oe}, 32'h0);
      format_sel <= fmt;
      master_sel <= ms;
      word_len <= wl;
      gap_en <= gap;
      dsp_width <= dw;
      tx_left <= l;
      tx_right <= r;
      drive_ws <= !ms;
      repeat (4) @(posedge core_clk);
      enable <= 1'b1;
      tx_valid <= 1'b1;
      n = 0;
      while (n < 4) begin
         @(posedge core_clk);
         if (rx_valid === 1'b1) n++;
      end
      chk(rx_left, sx(l, wl));
      if (fmt < 3'h5) chk(rx_right, sx(r, wl));
      chk({30'h0, ws_oe, sd_oe}, {30'h0, ms, 1'b1});
      @(posedge ws_line);
      t0 = $realtime;
      @(posedge ws_line);
      n = int'(($realtime - t0) / 80.0);
      chk(32'(n), (fmt < 3'h5) ? 32'h40 : ((fmt == 3'h5) ? 32'h80 : 32'h20));
   endtask : run_fmt

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 99000) begin
         miscompares++;
         conclude();
      end
   end

   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      chk({31'h0, tx_ready}, 32'h1);
      run_fmt(3'h0, 1'b1, 6'h18, 1'b0, 6'h01, 32'h00812345, 32'h00F00001);
      run_fmt(3'h0, 1'b1, 6'h20, 1'b0, 6'h01, 32'h80000001, 32'h7FFFFFFE);
      run_fmt(3'h0, 1'b1, 6'h08, 1'b0, 6'h01, 32'h00000080, 32'h0000007F);
      run_fmt(3'h1, 1'b1, 6'h18, 1'b0, 6'h01, 32'h00A5A5A5, 32'h00123456);
      run_fmt(3'h2, 1'b1, 6'h10, 1'b0, 6'h01, 32'h00008001, 32'h00007FFF);
      run_fmt(3'h3, 1'b1, 6'h18, 1'b0, 6'h01, 32'h00C00003, 32'h00300005);
      run_fmt(3'h3, 1'b1, 6'h18, 1'b1, 6'h03, 32'h00800001, 32'h007FFFFE);
      run_fmt(3'h4, 1'b1, 6'h18, 1'b0, 6'h01, 32'h00F0F0F0, 32'h000F0F0F);
      run_fmt(3'h5, 1'b1, 6'h18, 1'b0, 6'h01, 32'h00ABCDEF, 32'h0);
      run_fmt(3'h6, 1'b1, 6'h10, 1'b0, 6'h01, 32'h0000C3A5, 32'h0);
      run_fmt(3'h7, 1'b1, 6'h18, 1'b0, 6'h01, 32'h00876543, 32'h0);
      run_fmt(3'h1, 1'b0, 6'h18, 1'b0, 6'h01, 32'h00DEAD01, 32'h00BEEF02);
      run_fmt(3'h0, 1'b0, 6'h18, 1'b0, 6'h01, 32'h00C0FFEE, 32'h00135790);
      conclude();
   end
endmodule : tb_afsf_core
